// file: tdbw_pkg.sv
package tdbw_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_ARG0 = 12'h004;
  localparam logic [11:0] REG_ARG2 = 12'h00c;
  localparam logic [11:0] REG_RESULT = 12'h010;
  localparam logic [11:0] REG_IRQ_STAT = 12'h014;
  localparam logic [11:0] REG_IRQ_MASK = 12'h018;
  localparam logic [11:0] BUF_BASE = 12'h400;
  localparam int CMD_BUSY_BIT = 8;

  // ----------------------------------------------------------------
  // Command and argument layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WR_DATA_BLK = 8'h05;
  localparam int ARG_FIRST_BLK = 0;
  localparam int ARG_COUNT = 1;
  localparam int ARG_BUF_OFF = 2;
  localparam int ARG_KEY_SEL = 3;
  localparam int ARG_KEY = 4;
  localparam int KEY_LEN = 6;
  localparam int NUM_ARGS = ARG_KEY + KEY_LEN;
  localparam int KEY_SEL_TYPE_B = 7;
  localparam int KEY_SEL_INLINE = 6;
  localparam logic [5:0] KEY_SLOT_MAX = 6'h27;
  localparam int BLK_BYTES = 16;

  // ----------------------------------------------------------------
  // Result codes, interrupt bits, reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_AUTH_ERR = 8'h01;
  localparam logic [7:0] RES_WRITE_ERR = 8'h02;
  localparam logic [7:0] RES_ARG_ERR = 8'h03;
  localparam logic [7:0] RES_BAD_CMD = 8'h04;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // ----------------------------------------------------------------
  // Tag geometry: 4-block sectors below, 16-block sectors from here
  // ----------------------------------------------------------------
  localparam logic [7:0] BIG_SECT_BLK = 8'h80;
  localparam logic [7:0] SMALL_SECT_CNT = 8'h20;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_NEXT, ST_AUTH, ST_LOAD, ST_WRITE, ST_DONE
  } tdbw_st_e;

  function automatic logic [7:0] sector_of(input logic [7:0] blk);
    if (blk < BIG_SECT_BLK) begin
      return {2'h0, blk[7:2]};
    end
    return SMALL_SECT_CNT + {5'h0, blk[6:4]};
  endfunction

  // Last block of each sector carries keys and access bits
  function automatic logic is_trailer(input logic [7:0] blk);
    if (blk < BIG_SECT_BLK) begin
      return blk[1:0] == 2'h3;
    end
    return blk[3:0] == 4'hf;
  endfunction

endpackage

// file: tdbw_tag_model.sv
`timescale 1ns/10ps
module tdbw_tag_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Requests from the block
  input wire logic i_auth_req,
  input wire logic i_wr_req,
  // Scenario controls
  input wire logic [3:0] i_delay,
  input wire logic [3:0] i_auth_fail_at,
  input wire logic [3:0] i_wr_fail_at,
  input wire logic i_clr,
  // Answer
  output logic o_tag_done,
  output logic o_tag_ok
);
  logic [3:0] cnt_q;
  logic [3:0] na_q;
  logic [3:0] nw_q;
  logic armed_q;
  logic fail;
  logic req;
  logic answer;
  assign fail = i_auth_req ? (na_q == i_auth_fail_at) : (nw_q == i_wr_fail_at);
  assign req = i_auth_req || i_wr_req;
  assign answer = req && armed_q && cnt_q == i_delay;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {cnt_q, na_q, nw_q, o_tag_done, o_tag_ok} <= '0;
      armed_q <= 1'b1;
    end else begin
      // Ok toggles outside a pulse so nobody can lean on a stale value
      o_tag_done <= answer;
      o_tag_ok <= answer ? !fail : ~o_tag_ok;
      if (i_clr) begin
        na_q <= 4'h0;
        nw_q <= 4'h0;
      end else if (answer && i_auth_req) begin
        na_q <= na_q + 4'h1;
      end else if (answer) begin
        nw_q <= nw_q + 4'h1;
      end
      if (!req) begin
        armed_q <= 1'b1;
        cnt_q <= 4'h0;
      end else if (answer) begin
        // One answer per request, then wait for it to drop
        armed_q <= 1'b0;
      end else if (armed_q) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// file: tdbw_top.sv
`timescale 1ns/10ps
module tdbw_top
  import tdbw_pkg::*;
#(
  parameter int BUF_LEN = 256
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Tag engine: sector authentication
  output logic o_auth_req,
  output logic [7:0] o_auth_block,
  output logic o_auth_type_b,
  output logic o_auth_inline,
  output logic [5:0] o_auth_slot,
  output logic [47:0] o_auth_key,
  // Tag engine: block write
  output logic o_wr_req,
  output logic [7:0] o_wr_block,
  output logic [127:0] o_wr_data,
  // Tag engine answer
  input wire logic i_tag_done,
  input wire logic i_tag_ok,
  // Interrupt
  output logic o_irq
);

  localparam int BW = $clog2(BUF_LEN);

  typedef struct packed {
    tdbw_st_e st;
    logic [NUM_ARGS-1:0][7:0] arg;
    logic [7:0] blk;
    logic [7:0] left;
    logic [7:0] sect;
    logic authd;
    logic [8:0] idx;
    logic [3:0] cnt;
    logic [127:0] data;
    logic [7:0] result;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
    logic wait_rq;
    logic [31:0] rdata;
    logic auth_req;
    logic wr_req;
  } tdbw_state_s;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------
  // Data buffer, filled by software only
  // ----------------------------------------------------------------
  logic [7:0] mem [BUF_LEN];
  logic buf_hit;
  logic buf_wr;
  logic [BW-1:0] buf_bidx;
  assign buf_hit = i_address >= BUF_BASE &&
                   i_address < BUF_BASE + ADDR_W'(4 * BUF_LEN);
  assign buf_bidx = BW'((i_address - BUF_BASE) >> 2);
  assign buf_wr = i_write && !o_waitrequest && buf_hit && i_byteenable[0];
  always_ff @(posedge i_clk) begin
    if (buf_wr) begin
      mem[buf_bidx] <= i_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  tdbw_state_s q;
  tdbw_state_s d;
  logic arg_bad;
  logic [12:0] span;
  assign span = {5'h0, q.arg[ARG_BUF_OFF]} + {1'b0, q.arg[ARG_COUNT], 4'h0};
  assign arg_bad = q.arg[ARG_COUNT] == 8'h00 ||
                   span > 13'(BUF_LEN) ||
                   (!q.arg[ARG_KEY_SEL][KEY_SEL_INLINE] &&
                    q.arg[ARG_KEY_SEL][5:0] > KEY_SLOT_MAX);

  always_comb begin
    logic [1:0] set;
    logic [1:0] clr;
    logic acc;
    logic [31:0] rd;
    int n;
    set = 2'h0;
    clr = 2'h0;
    rd = 32'h0;
    n = 0;
    d = q;
    acc = (i_read || i_write) && !q.wait_rq;
    // Answer one cycle after the request appears; read data is ready by then
    d.wait_rq = !((i_read || i_write) && q.wait_rq);
    if (buf_hit) begin
      rd = {24'h0, mem[buf_bidx]};
    end else if (i_address >= REG_ARG0 && i_address <= REG_ARG2) begin
      for (int b = 0; b < 4; b++) begin
        n = 4 * int'((i_address - REG_ARG0) >> 2) + b;
        if (n < NUM_ARGS) begin
          rd[8*b+:8] = q.arg[n];
        end
      end
    end else begin
      unique case (i_address)
        REG_CMD: rd = {23'h0, q.st != ST_IDLE, CMD_WR_DATA_BLK};
        REG_RESULT: rd = {24'h0, q.result};
        REG_IRQ_STAT: rd = {30'h0, q.stat};
        REG_IRQ_MASK: rd = {30'h0, q.mask};
        default: rd = 32'h0;
      endcase
    end
    if (q.wait_rq) begin
      d.rdata = rd;
    end
    if (acc && i_write) begin
      // Arguments are locked while a command runs
      if (i_address >= REG_ARG0 && i_address <= REG_ARG2 && q.st == ST_IDLE) begin
        for (int b = 0; b < 4; b++) begin
          n = 4 * int'((i_address - REG_ARG0) >> 2) + b;
          if (n < NUM_ARGS && i_byteenable[b]) begin
            d.arg[n] = i_writedata[8*b+:8];
          end
        end
      end
      if (i_address == REG_CMD && i_byteenable[0] && q.st == ST_IDLE) begin
        if (i_writedata[7:0] == CMD_WR_DATA_BLK) begin
          d.st = ST_CHECK;
        end else begin
          d.result = RES_BAD_CMD;
          d.st = ST_DONE;
        end
      end
      if (i_address == REG_IRQ_STAT && i_byteenable[0]) begin
        clr = i_writedata[1:0];
      end
      if (i_address == REG_IRQ_MASK && i_byteenable[0]) begin
        d.mask = i_writedata[1:0];
      end
    end
    unique case (q.st)
      ST_IDLE: begin
      end
      ST_CHECK: begin
        d.blk = q.arg[ARG_FIRST_BLK];
        d.left = q.arg[ARG_COUNT];
        d.idx = {1'b0, q.arg[ARG_BUF_OFF]};
        d.authd = 1'b0;
        if (arg_bad) begin
          d.result = RES_ARG_ERR;
          d.st = ST_DONE;
        end else begin
          d.st = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (is_trailer(q.blk)) begin
          if (q.blk == 8'hff) begin
            d.result = RES_ARG_ERR;
            d.st = ST_DONE;
          end else begin
            d.blk = q.blk + 8'h01;
          end
        end else if (!q.authd || sector_of(q.blk) != q.sect) begin
          d.auth_req = 1'b1;
          d.st = ST_AUTH;
        end else begin
          d.cnt = 4'h0;
          d.st = ST_LOAD;
        end
      end
      ST_AUTH: begin
        if (i_tag_done) begin
          d.auth_req = 1'b0;
          if (i_tag_ok) begin
            d.authd = 1'b1;
            d.sect = sector_of(q.blk);
            d.cnt = 4'h0;
            d.st = ST_LOAD;
          end else begin
            d.result = RES_AUTH_ERR;
            d.st = ST_DONE;
          end
        end
      end
      ST_LOAD: begin
        // Byte 0 of the block ends up in the low byte
        d.data = {mem[q.idx[BW-1:0]], q.data[127:8]};
        d.idx = q.idx + 9'h001;
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(BLK_BYTES - 1)) begin
          d.wr_req = 1'b1;
          d.st = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (i_tag_done) begin
          d.wr_req = 1'b0;
          if (!i_tag_ok) begin
            d.result = RES_WRITE_ERR;
            d.st = ST_DONE;
          end else if (q.left == 8'h01) begin
            d.result = RES_OK;
            d.st = ST_DONE;
          end else if (q.blk == 8'hff) begin
            d.result = RES_ARG_ERR;
            d.st = ST_DONE;
          end else begin
            d.left = q.left - 8'h01;
            d.blk = q.blk + 8'h01;
            d.st = ST_NEXT;
          end
        end
      end
      ST_DONE: begin
        set[IRQ_DONE] = 1'b1;
        set[IRQ_ERR] = q.result != RES_OK;
        d.st = ST_IDLE;
      end
      default: d.st = ST_IDLE;
    endcase
    // A new event beats a simultaneous clear
    d.stat = (q.stat & ~clr) | set;
    d.irq = |(d.stat & d.mask);
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.wait_rq <= 1'b1;
      q.result <= RESULT_RST;
      q.mask <= IRQ_MASK_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_readdata = q.rdata;
  assign o_waitrequest = q.wait_rq;
  assign o_auth_req = q.auth_req;
  assign o_auth_block = q.blk;
  assign o_auth_type_b = q.arg[ARG_KEY_SEL][KEY_SEL_TYPE_B];
  assign o_auth_inline = q.arg[ARG_KEY_SEL][KEY_SEL_INLINE];
  assign o_auth_slot = q.arg[ARG_KEY_SEL][5:0];
  assign o_auth_key = q.arg[NUM_ARGS-1:ARG_KEY];
  assign o_wr_req = q.wr_req;
  assign o_wr_block = q.blk;
  assign o_wr_data = q.data;
  assign o_irq = q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  start_cmd_a: assert property (i_write && !o_waitrequest && i_address == REG_CMD &&
    i_byteenable[0] && i_writedata[7:0] == CMD_WR_DATA_BLK && q.st == ST_IDLE
    |=> q.st == ST_CHECK ##1 (o_auth_block == q.arg[ARG_FIRST_BLK] || q.st == ST_DONE))
    else $error("write command did not start");
  slot_range_a: assert property ($rose(o_auth_req) && !o_auth_inline |->
    o_auth_slot <= KEY_SLOT_MAX) else $error("key slot out of range at auth");
  key_type_a: assert property (o_auth_req |-> o_auth_type_b == $past(o_auth_type_b))
    else $error("key type changed during command");
  auth_first_a: assert property ($rose(o_wr_req) |-> q.authd &&
    q.sect == sector_of(o_wr_block)) else $error("block written without sector auth");
  auth_fail_a: assert property (o_auth_req && i_tag_done && !i_tag_ok |=>
    q.result == RES_AUTH_ERR && !o_wr_req ##1 q.st == ST_IDLE && q.stat[IRQ_ERR])
    else $error("auth failure not reported");
  skip_trailer_a: assert property (o_wr_req |-> !is_trailer(o_wr_block))
    else $error("trailer block written");
  write_ok_a: assert property (o_wr_req && i_tag_done && i_tag_ok && q.left == 8'h01
    |=> q.result == RES_OK ##1 q.stat[IRQ_DONE]) else $error("success not reported");
  write_fail_a: assert property (o_wr_req && i_tag_done && !i_tag_ok |=>
    q.result == RES_WRITE_ERR ##1 q.st == ST_IDLE) else $error("write failure lost");
  arg_check_a: assert property (q.st == ST_CHECK && arg_bad |=>
    q.result == RES_ARG_ERR && !o_auth_req && !o_wr_req) else $error("bad args not caught");
  load_len_a: assert property ($rose(o_wr_req) |-> $past(q.st, 16) == ST_LOAD &&
    q.idx == $past(q.idx, 16) + 9'h010) else $error("block not sixteen buffer bytes");

  multi_sect_c: cover property (o_wr_req && i_tag_done ##[1:40] $rose(o_auth_req));
  auth_err_c: cover property (o_auth_req && i_tag_done && !i_tag_ok);
  done_ok_c: cover property (q.st == ST_DONE && q.result == RES_OK);
  arg_err_c: cover property (q.st == ST_CHECK && arg_bad);

endmodule

// file: tdbw_top_tb.sv
`timescale 1ns/10ps
module tdbw_top_tb;
  import tdbw_pkg::*;
  localparam int BL = 64;
  logic clk, rst_n, rd, wr, wreq, a_req, a_tb, a_in, w_req, done, ok, irq, clr;
  logic a_prev, w_prev;
  logic [11:0] addr;
  logic [3:0] be, dly, fail_a, fail_w;
  logic [31:0] wd, rdata;
  logic [7:0] a_blk, w_blk;
  logic [5:0] a_sl;
  logic [47:0] a_key;
  logic [127:0] w_dat;
  logic [7:0] mem [BL];
  logic [63:0] got_a[$], ex_a[$];
  logic [135:0] got_w[$], ex_w[$];
  int seed = 18246;
  int num_errors = 0;
  int check_count = 0;
  tdbw_top #(.BUF_LEN(BL)) dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_address(addr),
    .i_read(rd), .i_write(wr), .i_byteenable(be), .i_writedata(wd), .o_readdata(rdata),
    .o_waitrequest(wreq), .o_auth_req(a_req), .o_auth_block(a_blk), .o_auth_type_b(a_tb),
    .o_auth_inline(a_in), .o_auth_slot(a_sl), .o_auth_key(a_key), .o_wr_req(w_req),
    .o_wr_block(w_blk), .o_wr_data(w_dat), .i_tag_done(done), .i_tag_ok(ok), .o_irq(irq));
  tdbw_tag_model tag_u (.i_clk(clk), .i_rst_n(rst_n), .i_auth_req(a_req), .i_wr_req(w_req),
    .i_delay(dly), .i_auth_fail_at(fail_a), .i_wr_fail_at(fail_w), .i_clr(clr),
    .o_tag_done(done), .o_tag_ok(ok));
  // ----------------------------------------------------------------
  // Tag link monitor
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (a_req && !a_prev) got_a.push_back({a_tb, a_in, a_sl, a_key, a_blk});
    if (w_req && !w_prev) got_w.push_back({w_blk, w_dat});
    a_prev <= a_req;
    w_prev <= w_req;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [135:0] g, input logic [135:0] e, input string m);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Request held from one rising edge until the edge that sees wait low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // Each pass sees the values the design sampled at that same edge
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    chk(n >= 50, 0, "bus timeout");
  endtask
  task automatic predict(input logic [7:0] f, c, o, s, input logic [47:0] k,
      input int fa, fw, output logic [7:0] r);
    int b, sec, cur, na, nw;
    logic [127:0] d;
    b = f;
    cur = -1;
    na = 0;
    nw = 0;
    r = RES_OK;
    if (c == 0 || o + 16 * c > BL || (!s[6] && s[5:0] > 39)) begin
      r = RES_ARG_ERR;
      return;
    end
    for (int i = 0; i < c; i++) begin
      while (b < 128 ? b % 4 == 3 : b % 16 == 15) b++;
      if (b > 255) begin
        r = RES_ARG_ERR;
        return;
      end
      sec = b < 128 ? b / 4 : 32 + (b - 128) / 16;
      if (sec != cur) begin
        ex_a.push_back({s[7], s[6], s[5:0], k, b[7:0]});
        if (na == fa) begin
          r = RES_AUTH_ERR;
          return;
        end
        na++;
        cur = sec;
      end
      for (int j = 0; j < 16; j++) d[8*j +: 8] = mem[o + 16 * i + j];
      ex_w.push_back({b[7:0], d});
      if (nw == fw) begin
        r = RES_WRITE_ERR;
        return;
      end
      nw++;
      b++;
    end
  endtask
  task automatic run(input logic [7:0] f, c, o, s, input int fa, fw, input logic [7:0] code);
    logic [31:0] q;
    logic [47:0] k;
    logic [7:0] r;
    logic [1:0] m;
    int n;
    k = {16'($random(seed)), $random(seed)};
    m = 2'($random(seed));
    ex_a.delete();
    ex_w.delete();
    predict(f, c, o, s, k, fa, fw, r);
    if (code !== CMD_WR_DATA_BLK) begin
      r = RES_BAD_CMD;
      ex_a.delete();
      ex_w.delete();
    end
    got_a.delete();
    got_w.delete();
    fail_a <= fa[3:0];
    fail_w <= fw[3:0];
    dly <= 4'($random(seed));
    clr <= 1'b1;
    bus(1, REG_IRQ_MASK, {30'h0, m}, q);
    clr <= 1'b0;
    bus(1, REG_ARG0, {s, o, c, f}, q);
    bus(1, REG_ARG0 + 12'h4, k[31:0], q);
    bus(1, REG_ARG2, {16'h0, k[47:32]}, q);
    bus(1, REG_CMD, {24'h0, code}, q);
    n = 0;
    do begin
      bus(0, REG_CMD, 0, q);
      n++;
    end while (q[CMD_BUSY_BIT] !== 1'b0 && n < 500);
    chk(n >= 500, 0, "busy stuck");
    bus(0, REG_RESULT, 0, q);
    chk(q[7:0], r, "result");
    chk(got_a.size(), ex_a.size(), "auth count");
    foreach (ex_a[i]) chk(got_a[i], ex_a[i], "auth");
    chk(got_w.size(), ex_w.size(), "write count");
    foreach (ex_w[i]) chk(got_w[i], ex_w[i], "write");
    bus(0, REG_IRQ_STAT, 0, q);
    chk(q[1:0], {r !== RES_OK, 1'b1}, "status");
    chk(irq, |({r !== RES_OK, 1'b1} & m), "irq");
    bus(1, REG_IRQ_STAT, 32'h3, q);
    bus(0, REG_IRQ_STAT, 0, q);
    chk({irq, q[1:0]}, 3'h0, "clear");
    $display("test done: blk %0d cnt %0d result %0d", f, c, r);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
  initial begin : main
    logic [31:0] q;
    logic [7:0] c;
    {rst_n, rd, wr, clr, addr, wd, dly} = '0;
    be = 4'hf;
    fail_a = 4'hf;
    fail_w = 4'hf;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, REG_RESULT, 0, q);
    chk(q, {24'h0, RESULT_RST}, "result reset");
    bus(0, REG_IRQ_MASK, 0, q);
    chk(q, {30'h0, IRQ_MASK_RST}, "mask reset");
    bus(0, 12'h100, 0, q);
    chk(q, 0, "unmapped");
    bus(0, REG_CMD, 0, q);
    chk(q[8:0], {1'b0, CMD_WR_DATA_BLK}, "cmd reset");
    for (int i = 0; i < BL; i++) begin
      mem[i] = 8'($random(seed));
      bus(1, BUF_BASE + 12'(4 * i), {24'h0, mem[i]}, q);
    end
    run(0, 1, 0, 8'h00, 15, 15, 8'h05);
    run(3, 2, 0, 8'h85, 15, 15, 8'h05);
    run(126, 3, 16, 8'h41, 15, 15, 8'h05);
    run(142, 2, 8, 8'hc0, 15, 15, 8'h05);
    run(254, 2, 0, 8'h00, 15, 15, 8'h05);
    run(6, 2, 0, 8'h27, 1, 15, 8'h05);
    run(9, 1, 0, 8'h00, 0, 15, 8'h05);
    run(0, 3, 1, 8'h02, 15, 1, 8'h05);
    run(4, 0, 0, 8'h00, 15, 15, 8'h05);
    run(4, 1, BL - 16, 8'h00, 15, 15, 8'h05);
    run(4, 1, BL - 15, 8'h00, 15, 15, 8'h05);
    run(4, 1, 0, 8'h28, 15, 15, 8'h05);
    run(4, 1, 0, 8'h68, 15, 15, 8'h05);
    run(4, 1, 0, 8'h00, 15, 15, 8'h06);
    for (int i = 0; i < 12; i++) begin
      c = 8'(1 + {$random(seed)} % 3);
      run(8'({$random(seed)} % 200), c, 8'({$random(seed)} % (BL - 16 * c + 1)),
        {2'($random(seed)), 6'({$random(seed)} % 40)}, 15, 15, 8'h05);
    end
    report_and_stop;
  end
endmodule
